// ===== hdl/pmx_pin_cell.sv
/*
 * One pin of the multiplexer: decodes the 2-bit select code against the
 * pin's function row and chooses who drives the pad.
 * Assumes peripherals present their own output value and enable.
 */
`timescale 1ns/1ps
module pmx_pin_cell
    import pmx_pkg::*;
(
    input  wire logic [1:0]            code,
    input  wire logic [17:0]           row,
    input  wire logic                  gpioOut,
    input  wire logic                  gpioDir,
    input  wire logic [PMX_FN_NUM-1:0] periphOut,
    input  wire logic [PMX_FN_NUM-1:0] periphOe,
    output pmx_fn_e                    fnSel,
    output pmx_drive_s                 drive
);

    // Function chosen by the code; reserved entries map to none
    always_comb begin
        case (code)
            2'h1:    fnSel = pmx_fn_e'(row[5:0]);
            2'h2:    fnSel = pmx_fn_e'(row[11:6]);
            2'h3:    fnSel = pmx_fn_e'(row[17:12]);
            default: fnSel = FN_NONE;
        endcase
    end

    // Pad driver source
    always_comb begin
        drive = '0;
        if (code == PMX_CODE_GPIO) begin
            drive.oe  = gpioDir;
            drive.out = gpioOut;
        end else if (fnSel != FN_NONE) begin
            drive.oe  = PMX_FN_DRIVES[fnSel] & periphOe[fnSel];
            drive.out = periphOut[fnSel];
        end
    end

endmodule : pmx_pin_cell

// ===== hdl/pmx_pkg.sv
/*
 * Shared constants and types for the port 0 pin function multiplexer:
 * register addresses, reset values, field layout, the list of peripheral
 * signals that can be routed and their idle and drive properties.
 * Assumes a 32-bit classic Wishbone register bus with byte addressing.
 */
package pmx_pkg;

    // ********************************************************************
    // Geometry and register map
    // ********************************************************************
    localparam int          PMX_PINS          = 20;
    localparam int          PMX_FIELD_W       = 2;
    localparam int          PMX_FN_NUM        = 44;
    localparam logic [31:0] PMX_ADR_SEL_LOW   = 32'he002c000;
    localparam logic [31:0] PMX_ADR_SEL_HIGH  = 32'he002c004;
    localparam logic [31:0] PMX_ADR_SHADOW    = 32'he002c008;
    localparam logic [31:0] PMX_SEL_LOW_RST   = 32'h00000000;
    localparam logic [31:0] PMX_SEL_HIGH_RST  = 32'h00000000;
    localparam logic [31:0] PMX_SEL_HIGH_MASK = 32'h000000ff;
    localparam logic [1:0]  PMX_CODE_GPIO     = 2'h0;

    // ********************************************************************
    // Routable peripheral signals; FN_NONE means GPIO or reserved
    // ********************************************************************
    typedef enum logic [5:0] {
        FN_FIRST_TXD, FN_FIRST_RXD, FN_PWM_OUT1, FN_PWM_OUT3, FN_EXT_IRQ0,
        FN_I2C_SCL, FN_T0_CAP0, FN_I2C_SDA, FN_T0_MAT0, FN_EXT_IRQ1,
        FN_SPI0_SCK, FN_T0_CAP1, FN_SPI0_MISO, FN_T0_MAT1, FN_SPI0_MOSI,
        FN_T0_CAP2, FN_SPI0_SSEL, FN_PWM_OUT2, FN_EXT_IRQ2, FN_SECOND_TXD,
        FN_PWM_OUT4, FN_SECOND_RXD, FN_PWM_OUT6, FN_EXT_IRQ3,
        FN_SECOND_RTS, FN_T1_CAP0, FN_SECOND_CTS, FN_T1_CAP1,
        FN_SECOND_DSR, FN_T1_MAT0, FN_CAN4_RECEIVE, FN_SECOND_DTR,
        FN_T1_MAT1, FN_CAN4_TRANSMIT, FN_SECOND_DCD, FN_SECOND_RI,
        FN_T0_MAT2, FN_T1_CAP2, FN_SPI1_SCK, FN_T1_MAT2, FN_T1_CAP3,
        FN_SPI1_MISO, FN_T1_MAT3, FN_SPI1_MOSI,
        FN_NONE = 6'h3f
    } pmx_fn_e;

    // Inputs whose idle level is high (serial idle, active-low strobes)
    localparam logic [PMX_FN_NUM-1:0] PMX_FN_IDLE_HI = 44'h00c54a502b2;
    // Signals the peripheral may drive onto the pad
    localparam logic [PMX_FN_NUM-1:0] PMX_FN_DRIVES  = 44'hed3a15a75ad;

    // ********************************************************************
    // Carriers
    // ********************************************************************
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [31:0] adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } pmx_wb_req_s;

    typedef struct packed {
        logic oe;
        logic out;
    } pmx_drive_s;

endpackage : pmx_pkg

// ===== hdl/pmx_port0_mux.sv
/*
 * Port 0 pin function multiplexer, pins 0 to 19. Two select registers on
 * a classic Wishbone bus route each pin to GPIO or a peripheral signal.
 * Assumes pad inputs are synchronous to clk and that peripherals and the
 * GPIO block sit beside it on the same clock.
 */
// Overview of operation
// - Low select register: 2-bit field n at bits 2n+1:2n picks pin n.
// - High select register bits 7:0 pick pins 16 to 19 in order.
// - Low register at first address, high register at the next word.
// - GPIO direction bit drives the pad only while GPIO is selected.
// - A peripheral function sets pad direction; GPIO direction ignored.
// - Code 00 is GPIO; every field resets to 0.
// - Pin 0: TXD, pwm_out1, reserved. Pin 1: RXD, pwm_out3, ext_irq0.
// - Pins 7, 8, 9: SSEL/pwm_out2/irq2, TXD/pwm_out4, RXD/pwm_out6/irq3.
// - Pin 14: DCD, ext_irq1. Pin 15: RI, ext_irq2. Code 11 reserved.
// - Pin 2: I2C clock, timer 0 capture 0, reserved.
// - Pins 4 to 6: SPI0 clock/MISO/MOSI, timer 0 cap1/mat1/cap2.
// - Pin 10: second port RTS, timer 1 capture 0, reserved.
// - Pin 11: second port CTS, timer 1 capture 1.
// - Pin 12: second port DSR, timer 1 match 0, can4_receive.
// - Pin 13: second port DTR, timer 1 match 1, can4_transmit.
// - Pin 19: timer 1 match 2, SPI1 MOSI, timer 1 capture 2.
`timescale 1ns/1ps
module pmx_port0_mux
    import pmx_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  arst_n,
    input  wire pmx_wb_req_s           wbReq,
    output logic                       wbAck,
    output logic [31:0]                wbDatO,
    input  wire logic [PMX_PINS-1:0]   gpioOut,
    input  wire logic [PMX_PINS-1:0]   gpioDir,
    input  wire logic [PMX_PINS-1:0]   padIn,
    output logic [PMX_PINS-1:0]        padOut,
    output logic [PMX_PINS-1:0]        padOe,
    input  wire logic [PMX_FN_NUM-1:0] periphOut,
    input  wire logic [PMX_FN_NUM-1:0] periphOe,
    output logic [PMX_FN_NUM-1:0]      periphIn
);

    // ********************************************************************
    // Function rows: {code 11, code 10, code 01} per pin
    // ********************************************************************
    function automatic logic [17:0] pmx_row(input int pin);
        logic [17:0] r;
        r = {FN_NONE, FN_NONE, FN_NONE};
        case (pin)
            0:  r = {FN_NONE, FN_PWM_OUT1, FN_FIRST_TXD};
            1:  r = {FN_EXT_IRQ0, FN_PWM_OUT3, FN_FIRST_RXD};
            2:  r = {FN_NONE, FN_T0_CAP0, FN_I2C_SCL};
            3:  r = {FN_EXT_IRQ1, FN_T0_MAT0, FN_I2C_SDA};
            4:  r = {FN_NONE, FN_T0_CAP1, FN_SPI0_SCK};
            5:  r = {FN_NONE, FN_T0_MAT1, FN_SPI0_MISO};
            6:  r = {FN_NONE, FN_T0_CAP2, FN_SPI0_MOSI};
            7:  r = {FN_EXT_IRQ2, FN_PWM_OUT2, FN_SPI0_SSEL};
            8:  r = {FN_NONE, FN_PWM_OUT4, FN_SECOND_TXD};
            9:  r = {FN_EXT_IRQ3, FN_PWM_OUT6, FN_SECOND_RXD};
            10: r = {FN_NONE, FN_T1_CAP0, FN_SECOND_RTS};
            // pin 11, code 11 left undefined
            11: r = {FN_NONE, FN_T1_CAP1, FN_SECOND_CTS};
            12: r = {FN_CAN4_RECEIVE, FN_T1_MAT0, FN_SECOND_DSR};
            13: r = {FN_CAN4_TRANSMIT, FN_T1_MAT1, FN_SECOND_DTR};
            14: r = {FN_NONE, FN_EXT_IRQ1, FN_SECOND_DCD};
            15: r = {FN_NONE, FN_EXT_IRQ2, FN_SECOND_RI};
            16: r = {FN_T0_CAP2, FN_T0_MAT2, FN_EXT_IRQ0};
            17: r = {FN_T1_MAT2, FN_SPI1_SCK, FN_T1_CAP2};
            18: r = {FN_T1_MAT3, FN_SPI1_MISO, FN_T1_CAP3};
            19: r = {FN_T1_CAP2, FN_SPI1_MOSI, FN_T1_MAT2};
            default: r = {FN_NONE, FN_NONE, FN_NONE};
        endcase
        return r;
    endfunction : pmx_row

    // ********************************************************************
    // Registers
    // ********************************************************************
    logic [31:0]                    selLow;
    logic [31:0]                    selHigh;
    logic [PMX_FIELD_W*PMX_PINS-1:0] selAll;
    logic [PMX_PINS-1:0]             shadow;
    pmx_fn_e                         fnSel [PMX_PINS];
    pmx_drive_s                      drive [PMX_PINS];

    // Register file on the bus
    pmx_wb_regs u_regs (
        .clk     (clk),
        .arst_n  (arst_n),
        .wbReq   (wbReq),
        .wbAck   (wbAck),
        .wbDatO  (wbDatO),
        .shadow  (shadow),
        .selLow  (selLow),
        .selHigh (selHigh)
    );

    assign selAll = {selHigh[PMX_FIELD_W*(PMX_PINS-16)-1:0], selLow};

    // ********************************************************************
    // Pad side, one cell per pin
    // ********************************************************************
    // routing follows the registers
    for (genvar p = 0; p < PMX_PINS; p++) begin : g_pin
        pmx_pin_cell u_cell (
            .code      (selAll[PMX_FIELD_W*p +: PMX_FIELD_W]),
            .row       (pmx_row(p)),
            .gpioOut   (gpioOut[p]),
            .gpioDir   (gpioDir[p]),
            .periphOut (periphOut),
            .periphOe  (periphOe),
            .fnSel     (fnSel[p]),
            .drive     (drive[p])
        );
        assign padOut[p] = drive[p].out;
        assign padOe[p]  = drive[p].oe;
    end

    // ********************************************************************
    // Peripheral input side
    // ********************************************************************
    // idle level when unrouted
    always_comb begin
        for (int f = 0; f < PMX_FN_NUM; f++) begin
            periphIn[f] = PMX_FN_IDLE_HI[f];
            for (int p = PMX_PINS - 1; p >= 0; p--) begin
                if (fnSel[p] == pmx_fn_e'(f[5:0])) begin
                    periphIn[f] = padIn[p];
                end
            end
        end
    end

    // Pins whose function is already taken by a lower pin
    always_comb begin
        shadow = '0;
        for (int p = 1; p < PMX_PINS; p++) begin
            for (int q = 0; q < p; q++) begin
                if (fnSel[p] != FN_NONE && fnSel[p] == fnSel[q]) begin
                    shadow[p] = 1'b1;
                end
            end
        end
    end

endmodule : pmx_port0_mux

// ===== hdl/pmx_wb_regs.sv
/*
 * Classic Wishbone slave holding the two function select registers and
 * returning the routing shadow status.
 * Assumes a master that holds each request until it samples ack.
 */
`timescale 1ns/1ps
module pmx_wb_regs
    import pmx_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire pmx_wb_req_s wbReq,
    output logic             wbAck,
    output logic [31:0]      wbDatO,
    input  wire logic [19:0] shadow,
    output logic [31:0]      selLow,
    output logic [31:0]      selHigh
);

    logic        ack_q;
    logic [31:0] dat_q;
    logic [31:0] selLow_q;
    logic [31:0] selHigh_q;
    logic        req;
    logic [31:0] wmask;

    // Request and byte-lane mask
    assign req = wbReq.cyc & wbReq.stb;
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            wmask[8*b +: 8] = {8{wbReq.sel[b]}};
        end
    end

    // Ack one cycle after the request, one cycle long
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    // Read data captured as ack rises; unmapped reads give zero
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dat_q <= 32'h00000000;
        end else if (req & ~ack_q) begin
            case (wbReq.adr)
                PMX_ADR_SEL_LOW:  dat_q <= selLow_q;
                PMX_ADR_SEL_HIGH: dat_q <= selHigh_q;
                PMX_ADR_SHADOW:   dat_q <= {12'h000, shadow};
                default:          dat_q <= 32'h00000000;
            endcase
        end
    end

    // Writes land at the edge where the master samples ack
    // register addresses
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            selLow_q  <= PMX_SEL_LOW_RST;
            selHigh_q <= PMX_SEL_HIGH_RST;
        end else if (req & ack_q & wbReq.we) begin
            if (wbReq.adr == PMX_ADR_SEL_LOW) begin
                selLow_q <= (selLow_q & ~wmask) | (wbReq.dat & wmask);
            end
            if (wbReq.adr == PMX_ADR_SEL_HIGH) begin
                selHigh_q <= ((selHigh_q & ~wmask) | (wbReq.dat & wmask))
                             & PMX_SEL_HIGH_MASK;
            end
        end
    end

    assign wbAck   = ack_q;
    assign wbDatO  = dat_q;
    assign selLow  = selLow_q;
    assign selHigh = selHigh_q;

endmodule : pmx_wb_regs

// ===== test/pmx_pad_model.sv
/* Pad model for port 0: each pad shows the mux drive while enabled,
   otherwise the level the outside world puts on it.
   Assumes one external source per pad and no drive fights. */
`timescale 1ns/1ps
module pmx_pad_model
    import pmx_pkg::*;
(
    input  wire logic [PMX_PINS-1:0] padOut,
    input  wire logic [PMX_PINS-1:0] padOe,
    input  wire logic [PMX_PINS-1:0] extLevel,
    output logic [PMX_PINS-1:0]      padIn
);
    // Wire level from the mux enable and the outside source
    assign padIn = (padOe & padOut) | (~padOe & extLevel);
endmodule : pmx_pad_model

// ===== test/pmx_port0_mux_props.sv
/* Checker for the port 0 function mux, bound to its top module.
   Assumes a write lands at the edge where ack is sampled. */
`timescale 1ns/1ps
module pmx_port0_mux_props
    import pmx_pkg::*;
(
    input wire logic                  clk,
    input wire logic                  arst_n,
    input wire pmx_wb_req_s           wbReq,
    input wire logic                  wbAck,
    input wire logic [31:0]           wbDatO,
    input wire logic [PMX_PINS-1:0]   gpioOut,
    input wire logic [PMX_PINS-1:0]   gpioDir,
    input wire logic [PMX_PINS-1:0]   padIn,
    input wire logic [PMX_PINS-1:0]   padOut,
    input wire logic [PMX_PINS-1:0]   padOe,
    input wire logic [PMX_FN_NUM-1:0] periphOut,
    input wire logic [PMX_FN_NUM-1:0] periphOe,
    input wire logic [PMX_FN_NUM-1:0] periphIn
);
    logic [31:0] selLow_q;
    logic [7:0]  selHigh_q;
    logic [39:0] sels;
    logic [19:0] isGpio;
    // Mirror of the select registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            selLow_q  <= 32'h0;
            selHigh_q <= 8'h0;
        end else if (wbReq.cyc && wbReq.stb && wbReq.we && wbAck) begin
            for (int b = 0; b < 4; b++) begin
                if (wbReq.sel[b] && wbReq.adr == PMX_ADR_SEL_LOW) begin
                    selLow_q[8*b+:8] <= wbReq.dat[8*b+:8];
                end
            end
            if (wbReq.sel[0] && wbReq.adr == PMX_ADR_SEL_HIGH) begin
                selHigh_q <= wbReq.dat[7:0];
            end
        end
    end
    assign sels = {selHigh_q, selLow_q};
    // Pins left on the GPIO code
    always_comb begin
        for (int p = 0; p < PMX_PINS; p++) begin
            isGpio[p] = sels[2*p+:2] == PMX_CODE_GPIO;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    property p_ackNext;
        wbReq.cyc && wbReq.stb && !wbAck |=> wbAck;
    endproperty
    a_ackNext: assert property (p_ackNext) else $error("ack late");
    property p_ackPulse;
        wbAck |=> !wbAck;
    endproperty
    a_ackPulse: assert property (p_ackPulse) else $error("ack held");
    property p_ackCause;
        wbAck |-> $past(wbReq.cyc && wbReq.stb);
    endproperty
    a_ackCause: assert property (p_ackCause) else $error("stray ack");
    property p_rdLow;
        wbAck && !wbReq.we && wbReq.adr == PMX_ADR_SEL_LOW |->
            wbDatO == selLow_q;
    endproperty
    a_rdLow: assert property (p_rdLow) else $error("low read");
    property p_rdHigh;
        wbAck && !wbReq.we && wbReq.adr == PMX_ADR_SEL_HIGH |->
            wbDatO == {24'h0, selHigh_q};
    endproperty
    a_rdHigh: assert property (p_rdHigh) else $error("high read");
    property p_gpio;
        ((padOe ^ gpioDir) & isGpio) == 0 &&
            ((padOut ^ gpioOut) & isGpio) == 0;
    endproperty
    a_gpio: assert property (p_gpio) else $error("gpio path");
    property p_txd;
        sels[1:0] == 2'h1 |-> padOut[0] == periphOut[FN_FIRST_TXD] &&
            padOe[0] == (PMX_FN_DRIVES[FN_FIRST_TXD] & periphOe[FN_FIRST_TXD]);
    endproperty
    a_txd: assert property (p_txd) else $error("txd route");
    property p_rxd;
        sels[3:2] == 2'h1 |-> !padOe[1] && periphIn[FN_FIRST_RXD] == padIn[1];
    endproperty
    a_rxd: assert property (p_rxd) else $error("rxd route");
    property p_irq3;
        periphIn[FN_EXT_IRQ3] == (sels[19:18] == 2'h3 ? padIn[9] :
            PMX_FN_IDLE_HI[FN_EXT_IRQ3]);
    endproperty
    a_irq3: assert property (p_irq3) else $error("irq3 input");
    c_write: cover property (wbAck && wbReq.we);
    c_read: cover property (wbAck && !wbReq.we);
    c_txd: cover property (sels[1:0] == 2'h1);
endmodule : pmx_port0_mux_props

// ===== test/port0_pin_function_mux_tb.sv
/* Self-checking bench for the port 0 function mux over Wishbone.
   Assumes the pad model closes the pad loop. */
`timescale 1ns/1ps
module port0_pin_function_mux_tb
    import pmx_pkg::*;
;
    logic        clk;
    logic        arst_n;
    pmx_wb_req_s req;
    logic        wbAck;
    logic [31:0] wbDatO;
    logic [19:0] gpioOut, gpioDir, ext, padIn, padOut, padOe;
    logic [43:0] periphOut, periphOe, periphIn;
    int          failures;
    int          n_tests;
    // Pin, code, function; entries in pin order
    localparam logic [12:0] ENT [17] = '{
        {5'h00, 2'h1, FN_FIRST_TXD}, {5'h01, 2'h3, FN_EXT_IRQ0},
        {5'h02, 2'h2, FN_T0_CAP0}, {5'h03, 2'h3, FN_EXT_IRQ1},
        {5'h06, 2'h2, FN_T0_CAP2}, {5'h07, 2'h2, FN_PWM_OUT2},
        {5'h09, 2'h3, FN_EXT_IRQ3}, {5'h0a, 2'h1, FN_SECOND_RTS},
        {5'h0b, 2'h2, FN_T1_CAP1}, {5'h0c, 2'h3, FN_CAN4_RECEIVE},
        {5'h0d, 2'h3, FN_CAN4_TRANSMIT}, {5'h0e, 2'h2, FN_EXT_IRQ1},
        {5'h0f, 2'h1, FN_SECOND_RI}, {5'h10, 2'h2, FN_T0_MAT2},
        {5'h11, 2'h1, FN_T1_CAP2}, {5'h12, 2'h3, FN_T1_MAT3},
        {5'h13, 2'h2, FN_SPI1_MOSI}};
    pmx_port0_mux u_pmx_port0_mux (.clk(clk), .arst_n(arst_n), .wbReq(req),
        .wbAck(wbAck), .wbDatO(wbDatO), .gpioOut(gpioOut), .gpioDir(gpioDir),
        .padIn(padIn), .padOut(padOut), .padOe(padOe),
        .periphOut(periphOut), .periphOe(periphOe), .periphIn(periphIn));
    pmx_pad_model u_pmx_pad_model (.padOut(padOut), .padOe(padOe),
        .extLevel(ext), .padIn(padIn));
    // Clock at 40 ns
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test
    task automatic chk(input string nm, input logic [43:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
        end
    endtask : chk
    // One classic cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [31:0] a, d,
                      input logic [3:0] s, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: s, dat: d};
        do begin
            @(posedge clk);
            n++;
        end while (wbAck !== 1'b1 && n < 20);
        q = wbDatO;
        req <= '0;
        if (wbAck !== 1'b1) begin
            failures++;
            finish_test();
        end
    endtask : wb
    initial begin : main
        logic [31:0] rd, val, adr;
        logic [12:0] e;
        int          p;
        failures = 0;
        n_tests = 0;
        arst_n = 1'b0;
        req = '0;
        gpioOut = 20'h0f0f0;
        gpioDir = 20'ha5a5a;
        ext = 20'h5a5a5;
        periphOut = '0;
        periphOe = '0;
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        wb(1'b0, PMX_ADR_SEL_LOW, 32'h0, 4'hf, rd);
        chk("low reset", rd, 32'h0);
        wb(1'b0, PMX_ADR_SEL_HIGH, 32'h0, 4'hf, rd);
        chk("high reset", rd, 32'h0);
        wb(1'b0, 32'he002c010, 32'h0, 4'hf, rd);
        chk("unmapped", rd, 32'h0);
        chk("gpio oe", padOe, gpioDir);
        chk("gpio out", padOut, gpioOut);
        chk("idle in", periphIn, PMX_FN_IDLE_HI);
        $display("test reset done");
        wb(1'b1, PMX_ADR_SEL_HIGH, 32'hffffffff, 4'hf, rd);
        wb(1'b0, PMX_ADR_SEL_HIGH, 32'h0, 4'hf, rd);
        chk("high mask", rd, 32'h000000ff);
        // only codes that the function table defines are written
        wb(1'b1, PMX_ADR_SEL_LOW, 32'hffffead5, 4'h3, rd);
        wb(1'b1, 32'he002c010, 32'hffffffff, 4'hf, rd);
        wb(1'b0, PMX_ADR_SEL_LOW, 32'h0, 4'hf, rd);
        chk("low lane", rd, 32'h0000ead5);
        @(negedge clk);
        chk("capture oe", padOe[4], 1'b0);
        chk("rxd in", periphIn[FN_FIRST_RXD], ext[1]);
        $display("test lanes done");
        for (int i = 0; i < 17; i++) begin
            e = ENT[i];
            p = int'(e[12:8]);
            adr = (p < 16) ? PMX_ADR_SEL_LOW : PMX_ADR_SEL_HIGH;
            val = 32'(e[7:6]) << (2 * (p % 16));
            @(posedge clk);
            periphOe <= '0;
            wb(1'b1, adr, val, 4'hf, rd);
            wb(1'b0, adr, 32'h0, 4'hf, rd);
            chk("readback", rd, val);
            for (int v = 0; v < 2; v++) begin
                @(posedge clk);
                periphOut <= {44{v[0]}};
                periphOe <= '1;
                ext <= {20{v[0]}};
                gpioOut <= {20{~v[0]}};
                gpioDir <= '1;
                @(negedge clk);
                if (PMX_FN_DRIVES[e[5:0]])
                    chk("pad", {padOe[p], padOut[p]}, {1'b1, v[0]});
                else
                    chk("in", {padOe[p], periphIn[e[5:0]]},
                        {1'b0, v[0]});
            end
            $display("test route pin %0d done", p);
        end
        // Pins 7 and 15 both pick ext_irq2 at opposite levels
        @(posedge clk);
        ext <= 20'h08000;
        wb(1'b1, PMX_ADR_SEL_LOW, 32'h8000c000, 4'hf, rd);
        wb(1'b0, PMX_ADR_SHADOW, 32'h0, 4'hf, rd);
        chk("shadow", rd, 32'h00008000);
        chk("first pin wins", periphIn[FN_EXT_IRQ2], 1'b0);
        $display("test shadow done");
        wb(1'b1, PMX_ADR_SEL_LOW, 32'h0, 4'hf, rd);
        wb(1'b1, PMX_ADR_SEL_HIGH, 32'h0, 4'hf, rd);
        @(negedge clk);
        chk("idle again", periphIn, PMX_FN_IDLE_HI);
        chk("gpio again", padOe, gpioDir);
        $display("test clear done");
        // Reset in mid-run must bring every field back to GPIO
        wb(1'b1, PMX_ADR_SEL_LOW, 32'h00000001, 4'hf, rd);
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        wb(1'b0, PMX_ADR_SEL_LOW, 32'h0, 4'hf, rd);
        chk("low after reset", rd, 32'h0);
        chk("gpio after reset", padOut, gpioOut);
        $display("test reset again done");
        finish_test();
    end
endmodule : port0_pin_function_mux_tb
bind pmx_port0_mux pmx_port0_mux_props u_pmx_port0_mux_props (.clk(clk),
    .arst_n(arst_n), .wbReq(wbReq), .wbAck(wbAck), .wbDatO(wbDatO),
    .gpioOut(gpioOut), .gpioDir(gpioDir), .padIn(padIn), .padOut(padOut),
    .padOe(padOe), .periphOut(periphOut), .periphOe(periphOe),
    .periphIn(periphIn));
